/* File: common/desc_emu_pkg.sv */
// Package: constants and types of the descriptor RAM emulation block
`default_nettype none
package desc_emu_pkg;
    // ==========================================================
    // Sizes
    localparam int RAM_BYTES = 512;
    localparam int RAM_WORDS = RAM_BYTES / 4;
    localparam int NUM_DESC = 10;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_HW_CONF = 8'h00;
    localparam logic [7:0] OFS_HS_LEN = 8'h04;
    localparam logic [7:0] OFS_FS_LEN = 8'h08;
    localparam logic [7:0] OFS_STR_LO = 8'h0C;
    localparam logic [7:0] OFS_STR_HI = 8'h10;
    localparam logic [7:0] OFS_FLAGS = 8'h14;
    localparam logic [7:0] OFS_ADDR_HI = 8'h18;
    localparam logic [7:0] OFS_ADDR_LO = 8'h1C;
    localparam logic [7:0] OFS_LED_CFG = 8'h20;
    localparam logic [7:0] OFS_WAKE = 8'h24;
    localparam logic [7:0] OFS_DP_ADDR = 8'h28;
    localparam logic [7:0] OFS_DP_DATA = 8'h2C;
    localparam logic [7:0] OFS_STATUS = 8'h30;

    // ==========================================================
    // Field positions and reset values
    localparam int HWC_EMU = 0;
    localparam int HWC_PROT = 1;
    localparam int HWC_TEST = 2;
    localparam logic [2:0] HWC_RST = 3'h0;
    localparam int FLAG_RWK = 0;
    localparam logic [7:0] FLAG_RST = 8'h00;
    localparam int LED_SELECT = 0;
    localparam int BM_OFS = 7;
    localparam int BM_RWK = 5;

    // ==========================================================
    // Values forced into served descriptors
    localparam logic [7:0] DEV_SIZE = 8'h12;
    localparam logic [7:0] DEV_TYPE = 8'h01;
    localparam logic [7:0] CFG_TYPE = 8'h02;

    // ==========================================================
    // Descriptor kinds, in RAM order
    typedef enum logic [3:0] {
        K_LANG = 4'b0000,
        K_STR1 = 4'b0001,
        K_STR2 = 4'b0010,
        K_STR3 = 4'b0011,
        K_STR4 = 4'b0100,
        K_STR5 = 4'b0101,
        K_HSDEV = 4'b0110,
        K_HSCFG = 4'b0111,
        K_FSDEV = 4'b1000,
        K_FSCFG = 4'b1001
    } desc_kind_t;

    typedef struct packed {
        desc_kind_t kind;
        logic [8:0] offset;
    } desc_req_t;

    typedef struct packed {
        logic [15:0] addr_hi;
        logic [31:0] addr_lo;
        logic led_select_bit;
        logic [10:0] wake;
        logic [7:0] flags;
    } ee_load_t;

    typedef struct packed {
        logic emu;
        logic [15:0] addr_hi;
        logic [31:0] addr_lo;
        logic [7:0] led_cfg;
        logic [10:0] wake;
        logic [7:0] flags;
    } cfg_out_t;

    typedef struct packed {
        logic [2:0] hw_conf;
        logic [15:0] hs_len;
        logic [15:0] fs_len;
        logic [31:0] str_lo;
        logic [15:0] str_hi;
        logic [7:0] flags;
        logic [15:0] addr_hi;
        logic [31:0] addr_lo;
        logic [7:0] led_cfg;
        logic [10:0] wake;
        logic [6:0] dp_addr;
        logic attr_done;
        logic ram_started;
        logic order_ok;
    } regs_t;

    localparam regs_t REGS_RST = '{
        hw_conf: HWC_RST, flags: FLAG_RST, default: '0};
endpackage
`default_nettype wire

/* File: design/desc_locate.sv */
// Descriptor start address chain and string presence
`default_nettype none
module desc_locate
    import desc_emu_pkg::*;
(
    // Descriptor lengths, RAM order
    input wire logic [NUM_DESC-1:0][7:0] lens,
    // Byte start of each descriptor
    output logic [NUM_DESC-1:0][8:0] starts,
    // Set when every string length is zero
    output logic no_strings
);
    // ==========================================================
    // Language descriptor always sits at the bottom
    assign starts[0] = 9'h000; // R10

    // Each start follows the previous one, word rounded
    for (genvar i = 1; i < NUM_DESC; i++) begin : g_chain
        logic [8:0] span;
        assign span = ({1'b0, lens[i-1]} + 9'h003) & 9'h1FC; // R21
        assign starts[i] = starts[i-1] + span; // R21
    end

    // Language id is dropped when no strings exist
    assign no_strings = ~|lens[5:1]; // R15
endmodule
`default_nettype wire

/* File: design/desc_ram_emu.sv */
// Descriptor RAM EEPROM emulation with AHB-Lite registers
//
// Summary of operation
// R1: driver order: control, attributes, RAM, enable, protect
// R2: attributes written before any descriptor RAM data
// R3: RAM config bmAttributes overwrites remote wakeup flag
// R4: EEPROM or driver loads address, LED, wake
// R5: absent descriptors get length zero
// R6: flag fields hidden while running from EEPROM
// R7: RAM bmAttributes agree with flag register
// R8: 512-byte descriptor RAM written via data port
// R9: descriptors start on word boundaries
// R10: RAM address zero holds language id
// R11: fixed descriptor order from address zero
// R12: device descriptor gets size 12h, type 1
// R13: configuration descriptor gets type 2
// R14: missing strings referenced by index zero
// R15: no strings means no language id
// R16: fixed release, packet size, configuration count
// R17: driver clears RAM test mode when done
// R18: emulation enable selects RAM as source
// R19: driver sets reset protection bit
// R20: protected content survives all but power-on
// R21: starts are word-rounded sums of lengths
//
// Added by the designer: the AHB-Lite slave port and the address map.
`default_nettype none
module desc_ram_emu
    import desc_emu_pkg::*;
(
    // Clock and power-on reset
    input wire logic hclk,
    input wire logic hresetn,
    // Soft system reset, not power-on
    input wire logic sys_reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // EEPROM side
    input wire logic eeprom_present,
    input wire logic ee_load_valid,
    input wire ee_load_t ee_load,
    // Descriptor requests from the USB engine
    input wire logic req_valid,
    input wire desc_req_t req,
    output logic resp_valid,
    output logic [7:0] resp_byte,
    output logic resp_absent,
    // Configuration seen by the rest of the chip
    output cfg_out_t cfg_out
);
    // ==========================================================
    // State
    regs_t regs, next_regs;
    logic [31:0] ram [RAM_WORDS];
    logic ap_valid, next_ap_valid;
    logic ap_write, next_ap_write;
    logic [7:0] ap_addr, next_ap_addr;
    logic rd_pend, next_rd_pend;
    logic next_hreadyout;
    logic [31:0] next_hrdata, rd_word;
    logic next_resp_valid, next_resp_absent;
    logic [7:0] next_resp_byte;
    logic [NUM_DESC-1:0][7:0] lens;
    logic [NUM_DESC-1:0][8:0] starts;
    logic no_strings;
    logic emu, ee_mode, wr_en, dp_wr, order_now;
    logic [8:0] rwk_addr, baddr;
    logic rwk_hit, rwk_bit, absent;
    logic [31:0] rword;
    logic [7:0] rbyte, pbyte, len;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ==========================================================
    // Mode decode
    assign emu = regs.hw_conf[HWC_EMU]; // R18
    assign ee_mode = eeprom_present && !emu;
    assign wr_en = ap_valid && ap_write;
    assign dp_wr = wr_en && ap_addr == OFS_DP_DATA
        && regs.hw_conf[HWC_TEST];

    // Lengths in RAM order for the start chain
    assign lens = {regs.fs_len[15:8], regs.fs_len[7:0],
        regs.hs_len[15:8], regs.hs_len[7:0],
        regs.str_hi[15:8], regs.str_hi[7:0],
        regs.str_lo[31:24], regs.str_lo[23:16],
        regs.str_lo[15:8], regs.str_lo[7:0]};

    desc_locate u_locate (
        .lens(lens),
        .starts(starts),
        .no_strings(no_strings)
    );

    // ==========================================================
    // Remote wakeup capture from the high-speed config
    // Order is judged once, at the first RAM write
    assign order_now = regs.ram_started ? regs.order_ok
        : regs.attr_done; // R3
    assign rwk_addr = starts[K_HSCFG] + 9'(BM_OFS);
    assign rwk_hit = dp_wr && order_now && lens[K_HSCFG] != 8'h00
        && regs.dp_addr == rwk_addr[8:2]; // R3
    assign rwk_bit = hwdata[{rwk_addr[1:0], 3'b000} + BM_RWK];

    // ==========================================================
    // Register next state
    always_comb begin
        next_regs = regs;
        if (sys_reset) begin
            // Protection spares everything but the port pointer
            if (regs.hw_conf[HWC_PROT]) begin
                next_regs.dp_addr = 7'h00; // R20
            end else begin
                next_regs = REGS_RST; // R20
            end
        end else begin
            // EEPROM load only when it is the source
            if (ee_load_valid && !emu) begin
                next_regs.addr_hi = ee_load.addr_hi; // R4
                next_regs.addr_lo = ee_load.addr_lo; // R4
                next_regs.led_cfg[LED_SELECT] = ee_load.led_select_bit; // R4
                next_regs.wake = ee_load.wake; // R4
                next_regs.flags = ee_load.flags; // R6
            end
            if (wr_en) begin
                unique case (ap_addr)
                    OFS_HW_CONF: next_regs.hw_conf = hwdata[2:0];
                    OFS_HS_LEN: next_regs.hs_len = hwdata[15:0];
                    OFS_FS_LEN: next_regs.fs_len = hwdata[15:0];
                    OFS_STR_LO: next_regs.str_lo = hwdata;
                    OFS_STR_HI: next_regs.str_hi = hwdata[15:0];
                    OFS_FLAGS: begin
                        // Locked while the EEPROM owns them
                        if (!ee_mode) begin
                            next_regs.flags = hwdata[7:0]; // R6
                        end
                    end
                    OFS_ADDR_HI: next_regs.addr_hi = hwdata[15:0];
                    OFS_ADDR_LO: next_regs.addr_lo = hwdata;
                    OFS_LED_CFG: next_regs.led_cfg = hwdata[7:0];
                    OFS_WAKE: next_regs.wake = hwdata[10:0];
                    OFS_DP_ADDR: next_regs.dp_addr = hwdata[8:2];
                    OFS_DP_DATA: begin
                        // Pointer walks on through the RAM
                        if (regs.hw_conf[HWC_TEST]) begin
                            next_regs.dp_addr = regs.dp_addr + 7'h01;
                            next_regs.ram_started = 1'b1;
                            next_regs.order_ok = order_now; // R2
                        end
                    end
                    default: begin
                    end
                endcase
                // Any length or flag write counts as attributes
                if (ap_addr inside {OFS_HS_LEN, OFS_FS_LEN,
                    OFS_STR_LO, OFS_STR_HI, OFS_FLAGS}) begin
                    next_regs.attr_done = 1'b1;
                end
                if (rwk_hit) begin
                    next_regs.flags[FLAG_RWK] = rwk_bit; // R3
                end
            end
        end
    end

    // Power-on reset clears all; soft reset is handled above
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            regs <= REGS_RST;
        end else begin
            regs <= next_regs;
        end
    end

    // RAM has no reset, so content outlives soft resets
    always_ff @(posedge hclk) begin
        if (dp_wr && !sys_reset) begin
            ram[regs.dp_addr] <= hwdata; // R8
        end
    end

    a_wake_patch: assert property ( // R3
        rwk_hit && !sys_reset |=>
            cfg_out.flags[FLAG_RWK] == $past(rwk_bit))
        else $error("remote wakeup flag not patched");

    a_ee_load: assert property ( // R4
        ee_load_valid && !emu && !sys_reset && !wr_en |=>
            cfg_out.addr_lo == $past(ee_load.addr_lo)
            && cfg_out.wake == $past(ee_load.wake))
        else $error("eeprom load not taken");

    a_keep_prot: assert property ( // R20
        sys_reset && regs.hw_conf[HWC_PROT] |=>
            $stable(cfg_out) && $stable(lens))
        else $error("protected content lost on soft reset");

    // ==========================================================
    // Read data mux
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (ap_addr)
            OFS_HW_CONF: rd_word[2:0] = regs.hw_conf;
            OFS_HS_LEN: rd_word[15:0] = regs.hs_len;
            OFS_FS_LEN: rd_word[15:0] = regs.fs_len;
            OFS_STR_LO: rd_word = regs.str_lo;
            OFS_STR_HI: rd_word[15:0] = regs.str_hi;
            OFS_FLAGS: rd_word[7:0] = ee_mode ? 8'h00
                : regs.flags; // R6
            OFS_ADDR_HI: rd_word[15:0] = regs.addr_hi;
            OFS_ADDR_LO: rd_word = regs.addr_lo;
            OFS_LED_CFG: rd_word[7:0] = regs.led_cfg;
            OFS_WAKE: rd_word[10:0] = regs.wake;
            OFS_DP_ADDR: rd_word[8:2] = regs.dp_addr;
            OFS_DP_DATA: rd_word = ram[regs.dp_addr];
            OFS_STATUS: rd_word[4:0] = {emu, regs.order_ok,
                regs.ram_started, regs.attr_done, no_strings};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Bus handshake: writes zero wait, reads one wait state
    // The wait lets a read see a write of the cycle before
    always_comb begin
        next_ap_valid = 1'b0;
        next_ap_write = ap_write;
        next_ap_addr = ap_addr;
        next_rd_pend = 1'b0;
        next_hreadyout = 1'b1;
        next_hrdata = hrdata;
        if (hsel && htrans[1] && hready && hsize == SIZE_WORD) begin
            next_ap_valid = 1'b1;
            next_ap_write = hwrite;
            next_ap_addr = haddr[7:0];
            if (!hwrite) begin
                next_rd_pend = 1'b1;
                next_hreadyout = 1'b0;
            end
        end
        if (rd_pend) begin
            next_hrdata = rd_word;
        end
    end

    // Bus registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_write <= 1'b0;
            ap_addr <= 8'h00;
            rd_pend <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
            hrdata <= 32'h0000_0000;
        end else begin
            ap_valid <= next_ap_valid;
            ap_write <= next_ap_write;
            ap_addr <= next_ap_addr;
            rd_pend <= next_rd_pend;
            hreadyout <= next_hreadyout;
            hresp <= HRESP_OKAY;
            hrdata <= next_hrdata;
        end
    end

    a_flags_hidden: assert property ( // R6
        rd_pend && ap_addr == OFS_FLAGS && ee_mode |=>
            hreadyout && hrdata == 32'h0000_0000)
        else $error("flags readable in eeprom mode");

    // ==========================================================
    // Descriptor serving: fetch, then patch size and type
    assign len = lens[req.kind];
    assign baddr = starts[req.kind] + req.offset; // R21
    assign rword = ram[baddr[8:2]];
    assign rbyte = rword[{baddr[1:0], 3'b000} +: 8];
    assign absent = !emu || regs.hw_conf[HWC_TEST] // R17
        || len == 8'h00 || req.offset >= {1'b0, len}
        || (req.kind == K_LANG && no_strings); // R15

    // Byte patch by kind and position
    always_comb begin
        pbyte = rbyte;
        if (req.kind inside {K_HSDEV, K_FSDEV}) begin
            if (req.offset == 9'h000) begin
                pbyte = DEV_SIZE; // R12
            end else if (req.offset == 9'h001) begin
                pbyte = DEV_TYPE; // R12
            end
        end else if (req.kind inside {K_HSCFG, K_FSCFG}) begin
            if (req.offset == 9'h001) begin
                pbyte = CFG_TYPE; // R13
            end
        end
    end

    // Answer next cycle; absent reads give zero
    always_comb begin
        next_resp_valid = req_valid;
        next_resp_byte = resp_byte;
        next_resp_absent = resp_absent;
        if (req_valid) begin
            next_resp_absent = absent; // R18
            next_resp_byte = absent ? 8'h00 : pbyte;
        end
    end

    // Response registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resp_valid <= 1'b0;
            resp_byte <= 8'h00;
            resp_absent <= 1'b0;
        end else begin
            resp_valid <= next_resp_valid;
            resp_byte <= next_resp_byte;
            resp_absent <= next_resp_absent;
        end
    end

    a_dev_size: assert property ( // R12
        req_valid && req.kind == K_HSDEV && req.offset == 9'h000
            && !absent |=> resp_valid && resp_byte == 8'h12)
        else $error("device size byte not forced");

    a_cfg_type: assert property ( // R13
        req_valid && req.kind == K_FSCFG && req.offset == 9'h001
            && !absent |=> resp_valid && resp_byte == 8'h02)
        else $error("config type byte not forced");

    a_lang_off: assert property ( // R15
        req_valid && req.kind == K_LANG && no_strings
            |=> resp_valid && resp_absent && resp_byte == 8'h00)
        else $error("language id served without strings");

    a_emu_source: assert property ( // R18
        req_valid && !emu |=> resp_valid && resp_absent)
        else $error("descriptor served while not emulating");

    // ==========================================================
    // Configuration out, straight from the registers
    assign cfg_out = '{emu: emu, addr_hi: regs.addr_hi,
        addr_lo: regs.addr_lo, led_cfg: regs.led_cfg,
        wake: regs.wake, flags: regs.flags};
endmodule
`default_nettype wire

/* File: bench/usb_host_model.sv */
// Descriptor request model standing in for the USB transfer engine
`default_nettype none
module usb_host_model
    import desc_emu_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Requests
    output logic req_valid,
    output desc_req_t req,
    // Answers
    input wire logic resp_valid,
    input wire logic [7:0] resp_byte,
    input wire logic resp_absent
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // One request; the answer is taken one cycle after the request edge
    task automatic fetch(input desc_kind_t kind, input logic [8:0] ofs,
        output logic ok, output logic [7:0] data, output logic absent);
        @(posedge hclk);
        req_valid <= 1'b1;
        req <= '{kind: kind, offset: ofs};
        @(posedge hclk);
        req_valid <= 1'b0;
        // Idle fields flip so a stale request never looks current
        req <= ~req;
        @(posedge hclk);
        ok = resp_valid;
        data = resp_byte;
        absent = resp_absent;
    endtask
endmodule
`default_nettype wire

/* File: bench/tb_descriptor_ram_eeprom_emulation.sv */
// Self-checking bench of the descriptor RAM emulation block
`default_nettype none
module tb_descriptor_ram_eeprom_emulation
    import desc_emu_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Signals
    logic hclk, hresetn, sys_reset, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic eeprom_present, ee_load_valid, req_valid, resp_valid, resp_absent;
    logic [7:0] resp_byte;
    ee_load_t ee_load;
    desc_req_t req;
    cfg_out_t cfg_out;
    int fails, samples_checked;
    // Single slave: its ready is the bus ready
    assign hready = hreadyout;

    desc_ram_emu DUT (.hclk(hclk), .hresetn(hresetn), .sys_reset(sys_reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .eeprom_present(eeprom_present), .ee_load_valid(ee_load_valid),
        .ee_load(ee_load), .req_valid(req_valid), .req(req),
        .resp_valid(resp_valid), .resp_byte(resp_byte),
        .resp_absent(resp_absent), .cfg_out(cfg_out));
    usb_host_model host (.hclk(hclk), .req_valid(req_valid), .req(req),
        .resp_valid(resp_valid), .resp_byte(resp_byte),
        .resp_absent(resp_absent));

    // ==========================================================
    // Clock, checking and closing
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // AHB-Lite master: waits are bounded, never a fixed latency
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            fails++;
            tally_and_finish();
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= SIZE_WORD;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        // Address lines move off so a stale address is never reused
        haddr <= ~haddr;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        check("hresp", 32'(HRESP_OKAY), 32'(hresp));
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a,
        input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        check(what, exp, rd);
    endtask
    task automatic serve(input desc_kind_t k, input logic [8:0] o,
        input logic absent, input logic [7:0] exp);
        logic ok, ab;
        logic [7:0] b;
        host.fetch(k, o, ok, b, ab);
        check("resp_valid", 32'h1, 32'(ok));
        check("resp_absent", 32'(absent), 32'(ab));
        check("resp_byte", 32'(exp), 32'(b));
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_values;
        rdchk("hw_conf", OFS_HW_CONF, 32'(HWC_RST));
        rdchk("flags", OFS_FLAGS, 32'(FLAG_RST));
        rdchk("unmapped", 8'h40, 32'h00000000);
        wr(8'h40, 32'hFFFFFFFF);
        rdchk("unmapped", 8'h40, 32'h00000000);
        $display("test reset_values done");
    endtask
    task automatic t_eeprom_load;
        eeprom_present <= 1'b1;
        @(posedge hclk);
        ee_load_valid <= 1'b1;
        ee_load <= '{addr_hi: 16'hA5C3, addr_lo: 32'h12345678,
            led_select_bit: 1'b1, wake: 11'h5A5, flags: 8'h01};
        @(posedge hclk);
        ee_load_valid <= 1'b0;
        ee_load <= ~ee_load;
        @(posedge hclk);
        check("addr_hi", 32'h0000A5C3, 32'(cfg_out.addr_hi));
        check("addr_lo", 32'h12345678, cfg_out.addr_lo);
        check("led select", 32'h1, 32'(cfg_out.led_cfg[LED_SELECT]));
        check("wake", 32'h000005A5, 32'(cfg_out.wake));
        rdchk("flags hidden", OFS_FLAGS, 32'h00000000);
        wr(OFS_FLAGS, 32'h00000000);
        // A write that slipped through would show one edge later
        @(posedge hclk);
        check("flags kept", 32'h00000001, 32'(cfg_out.flags));
        serve(K_LANG, 9'h000, 1'b1, 8'h00);
        eeprom_present <= 1'b0;
        $display("test eeprom_load done");
    endtask
    // Byte i holds i, bar the fixed device fields and string indices
    function automatic logic [7:0] ram_byte(input int a);
        case (a)
            14, 27, 28, 38, 49: return 8'h00;
            15: return 8'h02;
            19: return 8'h40;
            26, 29: return 8'h01;
            default: return 8'(a);
        endcase
    endfunction
    task automatic t_program;
        logic [7:0] b[4];
        // Control fields first, then attributes, then RAM
        wr(OFS_ADDR_HI, 32'h00003C5A);
        wr(OFS_ADDR_LO, 32'h89ABCDEF);
        wr(OFS_LED_CFG, 32'h00000000);
        wr(OFS_WAKE, 32'h0000023C);
        // The last write lands on the edge that ends its data phase
        @(posedge hclk);
        check("addr_lo", 32'h89ABCDEF, cfg_out.addr_lo);
        check("wake", 32'h0000023C, 32'(cfg_out.wake));
        // Lang 4, string one 6, HS device and config 18, rest absent
        wr(OFS_HS_LEN, 32'h00001212);
        wr(OFS_FS_LEN, 32'h00000000);
        wr(OFS_STR_LO, 32'h00000604);
        wr(OFS_STR_HI, 32'h00000000);
        wr(OFS_FLAGS, 32'h00000000);
        wr(OFS_HW_CONF, 32'h00000004);
        wr(OFS_DP_ADDR, 32'h00000000);
        // 13 words: byte 39 keeps bit 5 set for the wakeup patch
        for (int w = 0; w < 13; w++) begin
            for (int j = 0; j < 4; j++) b[j] = ram_byte(4 * w + j);
            wr(OFS_DP_DATA, {b[3], b[2], b[1], b[0]});
        end
        wr(OFS_HW_CONF, 32'h00000001);
        wr(OFS_HW_CONF, 32'h00000003);
        rdchk("flags patched", OFS_FLAGS, 32'h00000001);
        check("cfg flags", 32'h00000001, 32'(cfg_out.flags));
        check("emu", 32'h1, 32'(cfg_out.emu));
        rdchk("status", OFS_STATUS, 32'h0000001E);
        $display("test program done");
    endtask
    task automatic t_serve;
        serve(K_LANG, 9'h000, 1'b0, 8'h00);
        serve(K_LANG, 9'h004, 1'b1, 8'h00);
        serve(K_STR1, 9'h005, 1'b0, 8'h09);
        serve(K_STR2, 9'h000, 1'b1, 8'h00);
        serve(K_HSDEV, 9'h000, 1'b0, DEV_SIZE);
        serve(K_HSDEV, 9'h001, 1'b0, DEV_TYPE);
        serve(K_HSDEV, 9'h011, 1'b0, 8'h01);
        serve(K_HSDEV, 9'h012, 1'b1, 8'h00);
        serve(K_HSCFG, 9'h000, 1'b0, 8'h20);
        serve(K_HSCFG, 9'h001, 1'b0, CFG_TYPE);
        serve(K_FSDEV, 9'h000, 1'b1, 8'h00);
        serve(K_FSCFG, 9'h001, 1'b1, 8'h00);
        wr(OFS_HW_CONF, 32'h00000007);
        serve(K_HSDEV, 9'h002, 1'b1, 8'h00);
        wr(OFS_HW_CONF, 32'h00000003);
        wr(OFS_STR_LO, 32'h00000004);
        serve(K_LANG, 9'h000, 1'b1, 8'h00);
        rdchk("no strings", OFS_STATUS, 32'h0000001F);
        wr(OFS_STR_LO, 32'h00000604);
        $display("test serve done");
    endtask
    task automatic pulse_sys_reset;
        @(posedge hclk);
        sys_reset <= 1'b1;
        @(posedge hclk);
        sys_reset <= 1'b0;
    endtask
    task automatic t_sys_reset;
        pulse_sys_reset();
        rdchk("hw_conf kept", OFS_HW_CONF, 32'h00000003);
        rdchk("addr kept", OFS_ADDR_LO, 32'h89ABCDEF);
        rdchk("lens kept", OFS_HS_LEN, 32'h00001212);
        rdchk("pointer", OFS_DP_ADDR, 32'h00000000);
        serve(K_HSDEV, 9'h003, 1'b0, 8'h02);
        wr(OFS_HW_CONF, 32'h00000001);
        pulse_sys_reset();
        rdchk("hw_conf lost", OFS_HW_CONF, 32'h00000000);
        rdchk("addr lost", OFS_ADDR_LO, 32'h00000000);
        serve(K_HSDEV, 9'h002, 1'b1, 8'h00);
        $display("test sys_reset done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        fails = 0;
        samples_checked = 0;
        hresetn = 1'b0;
        sys_reset = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = SIZE_WORD;
        hwdata = 32'h00000000;
        eeprom_present = 1'b0;
        ee_load_valid = 1'b0;
        ee_load = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_values();
        t_eeprom_load();
        t_program();
        t_serve();
        t_sys_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
